// >>> rtl/spmz_buf2.v
// two-entry buffer with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
module spmz_buf2 (
    input wire clk_i,
    input wire rst_n_i,
    input wire [7:0] in_data_i,
    input wire in_valid_i,
    output wire in_ready_o,
    output wire [7:0] out_data_o,
    output wire out_valid_o,
    input wire out_ready_i
);
    reg [7:0] mem_q [0:1];
    reg wr_q;
    reg rd_q;
    reg [1:0] cnt_q;
    wire push;
    wire pop;
    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rd_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data_i;
                wr_q <= ~wr_q;
            end
            if (pop)
                rd_q <= ~rd_q;
            if (push && !pop)
                cnt_q <= cnt_q + 2'h1;
            else if (pop && !push)
                cnt_q <= cnt_q - 2'h1;
        end
    end
endmodule

// >>> rtl/spmz_consts.vh
// constants of the serial port block: modes, baud sources, bit counts
// assumes a single 20 MHz core clock
`ifndef SPMZ_CONSTS_VH
`define SPMZ_CONSTS_VH
`define SPMZ_MODE_SHIFT 2'h0
`define SPMZ_MODE_UART8 2'h1
`define SPMZ_MODE_UART9 2'h2
`define SPMZ_MODE_FIXED 2'h3
`define SPMZ_BSRC_TIMER1 1'h0
`define SPMZ_BSRC_BRGEN 1'h1
`define SPMZ_DATA_BITS 4'h8
`define SPMZ_FRAME_BITS 4'hA
`define SPMZ_M0_DIV 8'h10
`define SPMZ_M0_HALF 8'h08
`define SPMZ_OVS_COUNT 5'h10
`define SPMZ_OVS_MID 5'h08
`define SPMZ_FIX32_DIV 16'h0020
`define SPMZ_FIX16_DIV 16'h0010
`endif

// >>> rtl/spmz_serial_port.v
// serial port: shift-register mode 0, 10-bit asynchronous mode 1, fixed-rate mode 3
// assumes baud ticks from timer 1 or the baud generator (16x bit rate) come in on the core clock
`include "spmz_consts.vh"
module spmz_serial_port (
    input wire CLK_SYS_I,
    input wire RESETN_I,
    input wire [1:0] MODE_I,
    input wire BAUD_SRC_I,
    input wire FAST_I,
    input wire TIMER1_OVF_I,
    input wire BRGEN_TICK_I,
    input wire RX_ENABLE_I,
    input wire [7:0] TX_DATA_I,
    input wire TX_VALID_I,
    output reg TX_READY_O,
    output reg [7:0] RX_DATA_O,
    output reg RX_VALID_O,
    input wire RX_READY_I,
    input wire TX_DONE_CLR_I,
    input wire RX_DONE_CLR_I,
    output reg TX_DONE_O,
    output reg RX_DONE_O,
    output reg FRAME_ERR_O,
    output reg RECEIVED_NINTH_BIT_O,
    output reg IRQ_O,
    input wire RXD_I,
    output reg RXD_O,
    output reg RXD_OE_O,
    output reg TXD_O
);
    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    reg s1_q, s2_q, s3_q, rxd_q;
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s1_q <= 1'b1;
            s2_q <= 1'b1;
            s3_q <= 1'b1;
            rxd_q <= 1'b1;
        end else begin
            s1_q <= RXD_I;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q)
                rxd_q <= s3_q;
        end
    end

    // ------------------------------------------------------------
    // baud tick selection
    // ------------------------------------------------------------
    reg [15:0] fix_q;
    wire [15:0] fix_div = FAST_I ? `SPMZ_FIX16_DIV : `SPMZ_FIX32_DIV;
    // compare with >= so a divider switch in mid-count cannot run the counter round
    wire fix_tick = (fix_q >= fix_div - 16'h0001);
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I)
            fix_q <= 16'h0000;
        else
            fix_q <= fix_tick ? 16'h0000 : fix_q + 16'h0001;
    end
    // timer 2 is deliberately not a source
    wire ovs_tick = (MODE_I == `SPMZ_MODE_FIXED) ? fix_tick :
                    (BAUD_SRC_I == `SPMZ_BSRC_BRGEN) ? BRGEN_TICK_I : TIMER1_OVF_I;
    wire is_m0 = (MODE_I == `SPMZ_MODE_SHIFT);
    // 9-bit mode not carried in this block; treated as off
    wire is_async = (MODE_I == `SPMZ_MODE_UART8) || (MODE_I == `SPMZ_MODE_FIXED);

    // ------------------------------------------------------------
    // transmit buffer (double buffering)
    // ------------------------------------------------------------
    wire [7:0] tb_data;
    wire tb_valid, tb_in_ready;
    reg tb_pop;
    spmz_buf2 u_txbuf (
        .clk_i(CLK_SYS_I), .rst_n_i(RESETN_I),
        .in_data_i(TX_DATA_I), .in_valid_i(TX_VALID_I), .in_ready_o(tb_in_ready),
        .out_data_o(tb_data), .out_valid_o(tb_valid), .out_ready_i(tb_pop)
    );

    // ------------------------------------------------------------
    // transmitter / mode 0 shifter
    // ------------------------------------------------------------
    localparam TS_IDLE = 3'b001;
    localparam TS_M0 = 3'b010;
    localparam TS_AS = 3'b100;
    reg [2:0] ts_q;
    reg [9:0] tsh_q;
    reg [3:0] tbit_q;
    reg [7:0] m0cnt_q;
    reg [4:0] tovs_q;
    reg tx_done_set, m0_rx_done, m0_rxmode_q;
    reg [7:0] m0_rxsh_q;
    wire m0_edge_lo = (m0cnt_q == `SPMZ_M0_HALF - 8'h01);
    wire m0_edge_hi = (m0cnt_q == `SPMZ_M0_DIV - 8'h01);
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ts_q <= TS_IDLE;
            tsh_q <= 10'h3FF;
            tbit_q <= 4'h0;
            m0cnt_q <= 8'h00;
            tovs_q <= 5'h00;
            tx_done_set <= 1'b0;
            m0_rx_done <= 1'b0;
            m0_rxmode_q <= 1'b0;
            m0_rxsh_q <= 8'h00;
            tb_pop <= 1'b0;
            TXD_O <= 1'b1;
            RXD_O <= 1'b1;
            RXD_OE_O <= 1'b0;
        end else begin
            tb_pop <= 1'b0;
            tx_done_set <= 1'b0;
            m0_rx_done <= 1'b0;
            case (ts_q)
                TS_IDLE: begin
                    TXD_O <= 1'b1;
                    RXD_OE_O <= 1'b0;
                    m0cnt_q <= 8'h00;
                    tbit_q <= 4'h0;
                    tovs_q <= 5'h00;
                    if (is_m0 && tb_valid && !tb_pop) begin
                        tsh_q <= {2'b11, tb_data};
                        tb_pop <= 1'b1;
                        m0_rxmode_q <= 1'b0;
                        RXD_OE_O <= 1'b1;
                        RXD_O <= tb_data[0];
                        ts_q <= TS_M0;
                    end else if (is_m0 && RX_ENABLE_I && !RX_DONE_O && !m0_rx_done) begin
                        // the done pulse blocks re-arming until the flag has landed
                        m0_rxmode_q <= 1'b1;
                        ts_q <= TS_M0;
                    end else if (is_async && tb_valid && !tb_pop) begin
                        tsh_q <= {1'b1, tb_data, 1'b0};
                        tb_pop <= 1'b1;
                        ts_q <= TS_AS;
                    end
                end
                TS_M0: begin
                    // clock low for 8, high for 8 core clocks
                    m0cnt_q <= m0_edge_hi ? 8'h00 : m0cnt_q + 8'h01;
                    if (m0_edge_lo)
                        TXD_O <= 1'b0;
                    if (m0_edge_hi) begin
                        TXD_O <= 1'b1;
                        tsh_q <= {1'b1, tsh_q[9:1]};
                        RXD_O <= tsh_q[1];
                        m0_rxsh_q <= {rxd_q, m0_rxsh_q[7:1]}; // lsb first
                        tbit_q <= tbit_q + 4'h1;
                        if (tbit_q == `SPMZ_DATA_BITS - 4'h1) begin
                            ts_q <= TS_IDLE;
                            RXD_OE_O <= 1'b0;
                            tx_done_set <= ~m0_rxmode_q;
                            m0_rx_done <= m0_rxmode_q;
                        end
                    end
                end
                TS_AS: begin
                    TXD_O <= tsh_q[0];
                    if (ovs_tick) begin
                        tovs_q <= tovs_q + 5'h01;
                        if (tovs_q == `SPMZ_OVS_COUNT - 5'h01) begin
                            tovs_q <= 5'h00;
                            tsh_q <= {1'b1, tsh_q[9:1]};
                            tbit_q <= tbit_q + 4'h1;
                            if (tbit_q == `SPMZ_FRAME_BITS - 4'h1) begin
                                ts_q <= TS_IDLE;
                                tx_done_set <= 1'b1;
                            end
                        end
                    end
                end
                default: ts_q <= TS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // mode 1 and mode 3 receiver
    // ------------------------------------------------------------
    localparam RS_IDLE = 3'b001;
    localparam RS_BITS = 3'b010;
    localparam RS_HOLD = 3'b100;
    reg [2:0] rs_q;
    reg [4:0] rovs_q;
    reg [3:0] rbit_q;
    reg [8:0] rsh_q;
    reg rxd_prev_q, as_rx_done;
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rs_q <= RS_IDLE;
            rovs_q <= 5'h00;
            rbit_q <= 4'h0;
            rsh_q <= 9'h000;
            rxd_prev_q <= 1'b1;
            as_rx_done <= 1'b0;
            FRAME_ERR_O <= 1'b0;
            RECEIVED_NINTH_BIT_O <= 1'b0;
        end else begin
            rxd_prev_q <= rxd_q;
            as_rx_done <= 1'b0;
            case (rs_q)
                RS_IDLE: begin
                    rovs_q <= 5'h00;
                    rbit_q <= 4'h0;
                    if (is_async && RX_ENABLE_I && rxd_prev_q && !rxd_q)
                        rs_q <= RS_BITS; // start edge
                end
                RS_BITS: if (ovs_tick) begin
                    rovs_q <= rovs_q + 5'h01;
                    if (rovs_q == `SPMZ_OVS_MID - 5'h01) begin
                        if (rbit_q == 4'h0 && rxd_q)
                            rs_q <= RS_IDLE; // false start
                        else if (rbit_q == `SPMZ_FRAME_BITS - 4'h1) begin
                            RECEIVED_NINTH_BIT_O <= rxd_q;
                            FRAME_ERR_O <= ~rxd_q;
                            rsh_q <= {rxd_q, rsh_q[8:1]};
                            as_rx_done <= 1'b1;
                            rs_q <= RS_HOLD;
                        end else
                            rsh_q <= {rxd_q, rsh_q[8:1]}; // centre sample
                    end
                    if (rovs_q == `SPMZ_OVS_COUNT - 5'h01) begin
                        rovs_q <= 5'h00;
                        rbit_q <= rbit_q + 4'h1;
                    end
                end
                RS_HOLD: if (rxd_q)
                    rs_q <= RS_IDLE;
                default: rs_q <= RS_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // receive data stage and flags
    // ------------------------------------------------------------
    wire rx_done_set = m0_rx_done | as_rx_done;
    // the stop bit sits in rsh_q[8] once the frame is done
    wire [7:0] rx_word = m0_rx_done ? m0_rxsh_q : rsh_q[7:0];
    always @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RX_DATA_O <= 8'h00;
            RX_VALID_O <= 1'b0;
            TX_DONE_O <= 1'b0;
            RX_DONE_O <= 1'b0;
            IRQ_O <= 1'b0;
            TX_READY_O <= 1'b0;
        end else begin
            TX_READY_O <= tb_in_ready;
            if (rx_done_set) begin
                RX_DATA_O <= rx_word;
                RX_VALID_O <= 1'b1;
            end else if (RX_READY_I)
                RX_VALID_O <= 1'b0;
            // set wins over clear
            TX_DONE_O <= tx_done_set | (TX_DONE_O & ~TX_DONE_CLR_I);
            RX_DONE_O <= rx_done_set | (RX_DONE_O & ~RX_DONE_CLR_I);
            IRQ_O <= tx_done_set | rx_done_set | (TX_DONE_O & ~TX_DONE_CLR_I) | (RX_DONE_O & ~RX_DONE_CLR_I);
        end
    end
endmodule

// >>> verif/spmz_remote_dev.sv
// remote serial device on the two pins
// assumes the bench sets bit_ns to the bit time in use
module spmz_remote_dev (
    input wire txd_i,
    input wire en_i,
    output logic rxd_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // frame send and capture
    // ----
    int bit_ns = 1600;
    logic [7:0] sh;
    logic [7:0] got_q[$];
    initial rxd_o = 1'b1;
    task automatic send(input logic [7:0] d, input logic stp);
        logic [9:0] f;
        f = {stp, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd_o = f[i];
            #(bit_ns);
        end
        rxd_o = 1'b1;
    endtask
    // mode 0: new bit at each falling shift clock, released after the last rise
    task automatic shift_in(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            @(negedge txd_i);
            rxd_o = d[i];
        end
        @(posedge txd_i);
        rxd_o = 1'b1;
    endtask
    always begin
        @(negedge txd_i);
        #(bit_ns / 2);
        for (int i = 0; i < 8; i++) begin
            #(bit_ns);
            sh = {txd_i, sh[7:1]};
        end
        #(bit_ns);
        if (en_i && txd_i) got_q.push_back(sh);
    end
endmodule

// >>> verif/spmz_serial_port_asserts.sv
// checker on the serial port top ports
// assumes it is bound to spmz_serial_port
module spmz_serial_port_asserts (
    input wire CLK_SYS_I,
    input wire RESETN_I,
    input wire [1:0] MODE_I,
    input wire RX_READY_I,
    input wire TX_DONE_CLR_I,
    input wire RX_VALID_O,
    input wire TX_DONE_O,
    input wire RX_DONE_O,
    input wire FRAME_ERR_O,
    input wire RECEIVED_NINTH_BIT_O,
    input wire IRQ_O,
    input wire RXD_O,
    input wire RXD_OE_O,
    input wire TXD_O
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // properties
    // ----
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESETN_I);
    property p_oe; RXD_OE_O |-> MODE_I == 2'h0; endproperty
    a_oe: assert property (p_oe) else $error("pin driven off mode 0");
    property p_clk; MODE_I == 2'h0 && $fell(TXD_O) |-> (!TXD_O) [*8] ##1 TXD_O; endproperty
    a_clk: assert property (p_clk) else $error("shift clock low phase");
    property p_dat; MODE_I == 2'h0 && RXD_OE_O && $past(RXD_OE_O) && !TXD_O |-> $stable(RXD_O); endproperty
    a_dat: assert property (p_dat) else $error("shift data moved");
    property p_irq; TX_DONE_O || RX_DONE_O |-> ##[0:1] IRQ_O; endproperty
    a_irq: assert property (p_irq) else $error("irq missing");
    property p_txd; TX_DONE_O && !TX_DONE_CLR_I |=> TX_DONE_O; endproperty
    a_txd: assert property (p_txd) else $error("tx done lost");
    property p_rxv; RX_VALID_O && !RX_READY_I |=> RX_VALID_O; endproperty
    a_rxv: assert property (p_rxv) else $error("rx valid lost");
    property p_fe; $rose(FRAME_ERR_O) |=> RX_DONE_O; endproperty
    a_fe: assert property (p_fe) else $error("frame error off frame");
    property p_nb; $changed(RECEIVED_NINTH_BIT_O) |=> RX_DONE_O; endproperty
    a_nb: assert property (p_nb) else $error("stop copy off frame");
    c_tx: cover property ($rose(TX_DONE_O));
    c_fe: cover property ($rose(FRAME_ERR_O));
    c_m0: cover property ($rose(RXD_OE_O));
    c_m0rx: cover property ($rose(RX_DONE_O) && MODE_I == 2'h0);
endmodule
bind spmz_serial_port spmz_serial_port_asserts u_chk (.*);

// >>> verif/tb_spmz_serial_port.sv
// bench of the serial port: tx burst, rx with stop errors, fixed rate, shift out
// assumes spmz_remote_dev and the bound checker are compiled in
module tb_spmz_serial_port;
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // stimulus and checks
    // ----
    logic CLK_SYS_I = 1'b0, RESETN_I = 1'b0, BAUD_SRC_I = 1'b0, FAST_I = 1'b0, RX_ENABLE_I = 1'b1;
    logic TX_VALID_I = 1'b0, RX_READY_I = 1'b0, TX_DONE_CLR_I = 1'b0, RX_DONE_CLR_I = 1'b0;
    logic [1:0] MODE_I = 2'h1;
    logic [7:0] TX_DATA_I = 8'h00;
    wire TX_READY_O, RX_VALID_O, TX_DONE_O, RX_DONE_O, FRAME_ERR_O, RECEIVED_NINTH_BIT_O;
    wire IRQ_O, RXD_O, RXD_OE_O, TXD_O, rem_rxd;
    wire [7:0] RX_DATA_O;
    int n_fail = 0, tests_run = 0, tick = 0;
    wire TIMER1_OVF_I = tick % 2 == 0;
    wire BRGEN_TICK_I = tick % 3 == 0;
    wire RXD_I = RXD_OE_O ? RXD_O : rem_rxd;
    spmz_serial_port dut (.*);
    spmz_remote_dev u_rem (.txd_i(TXD_O), .en_i(MODE_I != 2'h0), .rxd_o(rem_rxd));
    initial forever #25 CLK_SYS_I = ~CLK_SYS_I;
    always @(negedge CLK_SYS_I) tick <= tick + 1;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic push(input logic [7:0] d);
        for (int i = 0; i < 3000 && TX_READY_O !== 1'b1; i++) @(negedge CLK_SYS_I);
        TX_DATA_I = d;
        TX_VALID_I = 1'b1;
        @(negedge CLK_SYS_I);
        TX_VALID_I = 1'b0;
        @(negedge CLK_SYS_I);
    endtask
    task automatic clr;
        TX_DONE_CLR_I = 1'b1;
        RX_DONE_CLR_I = 1'b1;
        @(negedge CLK_SYS_I);
        TX_DONE_CLR_I = 1'b0;
        RX_DONE_CLR_I = 1'b0;
        @(negedge CLK_SYS_I);
        chk({TX_DONE_O, RX_DONE_O, IRQ_O}, 8'h00);
    endtask
    task automatic tx_end;
        for (int i = 0; i < 600 && TX_DONE_O !== 1'b1; i++) @(negedge CLK_SYS_I);
        @(negedge CLK_SYS_I);
        chk({TX_DONE_O, IRQ_O}, 8'h03);
        clr;
    endtask
    task automatic rd(input logic [7:0] d);
        for (int i = 0; i < 600 && RX_VALID_O !== 1'b1; i++) @(negedge CLK_SYS_I);
        repeat (3) @(negedge CLK_SYS_I);
        chk(RX_DATA_O, d);
        chk({RX_VALID_O, RX_DONE_O, IRQ_O}, 8'h07);
        RX_READY_I = 1'b1;
        @(negedge CLK_SYS_I);
        RX_READY_I = 1'b0;
    endtask
    task automatic t_tx_burst;
        logic [7:0] w[3] = '{8'h01, 8'h80, 8'hC3};
        foreach (w[i]) push(w[i]);
        chk(TX_READY_O, 8'h00);
        for (int i = 0; i < 1500 && u_rem.got_q.size() < 3; i++) @(negedge CLK_SYS_I);
        foreach (w[i]) chk(u_rem.got_q.size() > i ? u_rem.got_q[i] : 8'hXX, w[i]);
        u_rem.got_q.delete();
        clr;
        tx_end;
    endtask
    task automatic t_rx;
        BAUD_SRC_I = 1'b1;
        u_rem.bit_ns = 2400;
        u_rem.send(8'hA5, 1'b1);
        rd(8'hA5);
        chk({RECEIVED_NINTH_BIT_O, FRAME_ERR_O}, 8'h02);
        clr;
        u_rem.send(8'h3C, 1'b0);
        rd(8'h3C);
        chk({RECEIVED_NINTH_BIT_O, FRAME_ERR_O}, 8'h01);
        clr;
    endtask
    task automatic t_fixed;
        MODE_I = 2'h3;
        for (int f = 0; f < 2; f++) begin
            FAST_I = f[0];
            u_rem.bit_ns = f ? 12800 : 25600;
            push(8'h5A + 8'(f));
            for (int i = 0; i < 6000 && u_rem.got_q.size() == 0; i++) @(negedge CLK_SYS_I);
            chk(u_rem.got_q.size() > 0 ? u_rem.got_q.pop_front() : 8'hXX, 8'h5A + 8'(f));
            tx_end;
        end
    endtask
    task automatic t_shift;
        logic [7:0] got = 8'h00;
        logic l_txd = 1'b1, l_dat = 1'b0, l_oe = 1'b0;
        int n = 0;
        RX_ENABLE_I = 1'b0;
        MODE_I = 2'h0;
        push(8'h96);
        repeat (300) begin
            if (!l_txd && TXD_O && l_oe) begin
                got = {l_dat, got[7:1]};
                n++;
            end
            l_txd = TXD_O;
            l_dat = RXD_O;
            l_oe = RXD_OE_O;
            @(negedge CLK_SYS_I);
        end
        chk(got, 8'h96);
        chk(8'(n), 8'h08);
        chk({RXD_OE_O, TX_DONE_O}, 8'h01);
    endtask
    task automatic t_shift_in;
        RX_ENABLE_I = 1'b1;
        fork
            u_rem.shift_in(8'h69);
            rd(8'h69);
        join
        RX_ENABLE_I = 1'b0;
        clr;
    endtask
    task automatic print_verdict;
        if (n_fail == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge CLK_SYS_I);
        RESETN_I = 1'b1;
        chk({TXD_O, RXD_OE_O, TX_DONE_O, RX_DONE_O, IRQ_O}, 8'h10);
        repeat (2) @(negedge CLK_SYS_I);
        t_tx_burst;
        t_rx;
        t_fixed;
        t_shift;
        t_shift_in;
        print_verdict;
    end
    initial begin
        #3000000;
        n_fail++;
        print_verdict;
    end
endmodule
